// ---- pkg/ppsm_map.vh ----
`ifndef PPSM_MAP_VH
`define PPSM_MAP_VH
// Legacy game-card FM synthesizer block base and size
`define PPSM_LEGACY_FM_BASE 10'h388
`define PPSM_FM_SPAN 10'h008
// Peripheral window sizes
`define PPSM_SPAN_NARROW 10'h004
`define PPSM_SPAN_WIDE 10'h008
// Reset values of polarity bits
`define PPSM_SYNTH_POL_RST 1'b0
`define PPSM_CD_POL_RST 1'b1
`define PPSM_MODEM_POL_RST 1'b0
// Default alternate CDROM span minus one
`define PPSM_ALT_SPAN_RST 3'h0
// Data bit shared with floppy controller
`define PPSM_SHARED_BIT 7
`endif

// ---- logic/ppsm_port_mux.v ----
`timescale 1ns/1ps
`include "ppsm_map.vh"
module ppsm_port_mux #(
  parameter AW = 10,
  parameter DW = 8
) (
  input wire i_clock,
  input wire i_rst_b,
  input wire [AW-1:0] i_host_addr,
  input wire i_host_rd_b,
  input wire i_host_wr_b,
  input wire [DW-1:0] i_host_data,
  input wire [AW-1:0] i_synth_base,
  input wire [AW-1:0] i_cd_base_a,
  input wire [AW-1:0] i_alt_cd_base,
  input wire [AW-1:0] i_modem_base,
  input wire [2:0] i_alt_cd_span_m1,
  input wire i_ext_synth_enable,
  input wire i_addr_bit2_enable,
  input wire i_vol_ctrl_enable,
  input wire i_synth_irq_polarity,
  input wire i_cd_irq_polarity,
  input wire i_modem_irq_polarity,
  input wire i_alt_cd_bit7_disable,
  input wire i_host_data_drive_disable,
  input wire i_serial_port_enable,
  input wire i_serial_port_pin_select,
  input wire i_general_ctrl_out0,
  input wire i_general_ctrl_out1,
  input wire i_vol_down,
  input wire i_periph_read_strobe_strap,
  input wire i_periph_write_strobe_strap,
  input wire i_synth_irq_pin,
  input wire i_cd_irq_pin,
  input wire i_cd_dma_request_pin,
  input wire i_modem_irq_pin,
  input wire [DW-1:0] i_periph_data,
  input wire i_part_reset,
  output reg [DW-1:0] o_host_data,
  output reg o_host_data_oe,
  output reg [DW-1:0] o_periph_data,
  output reg o_periph_data_oe,
  output reg [2:0] o_periph_addr,
  output reg o_periph_addr2_is_addr,
  output reg o_periph_read_strobe_b,
  output reg o_periph_write_strobe_b,
  output reg o_periph_reset,
  output reg o_synth_chip_select_b,
  output reg o_shared_pin,
  output reg o_shared_pin_oe,
  output reg o_cd_pins_are_upper_addr,
  output reg o_cd_chip_select_b,
  output reg o_cd_dma_ack_b,
  output reg o_modem_chip_select_b,
  output reg o_modem_pins_active,
  output reg o_alt_cd_active,
  output reg o_synth_irq,
  output reg o_cd_irq,
  output reg o_cd_dma_request,
  output reg o_modem_irq
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam NS = AW + 2*DW + 10;
  // Idle levels: host strobes high, all else low
  localparam [NS-1:0] SYNC_IDLE = {{(AW+2*DW){1'b0}}, 2'h3, 8'h00};
  wire [NS-1:0] raw_in;
  reg [NS-1:0] meta_r;
  reg [NS-1:0] sync_r;
  assign raw_in = {i_host_addr, i_host_data, i_periph_data, i_host_rd_b, i_host_wr_b,
                   i_periph_read_strobe_strap, i_periph_write_strobe_strap,
                   i_synth_irq_pin, i_cd_irq_pin, i_cd_dma_request_pin,
                   i_modem_irq_pin, i_vol_down, i_part_reset};

  // Two-stage capture of pin inputs
  always @(posedge i_clock) begin
    if (!i_rst_b) begin
      meta_r <= SYNC_IDLE;
      sync_r <= SYNC_IDLE;
    end else begin
      meta_r <= raw_in;
      sync_r <= meta_r;
    end
  end

  wire [AW-1:0] s_addr = sync_r[NS-1 -: AW];
  wire [DW-1:0] s_hdata = sync_r[NS-AW-1 -: DW];
  wire [DW-1:0] s_pdata = sync_r[NS-AW-DW-1 -: DW];
  wire s_rd_b = sync_r[9];
  wire s_wr_b = sync_r[8];
  wire s_rd_strap = sync_r[7];
  wire s_wr_strap = sync_r[6];
  wire s_synth_irq = sync_r[5];
  wire s_cd_irq = sync_r[4];
  wire s_cd_drq = sync_r[3];
  wire s_modem_irq = sync_r[2];
  wire s_vol_down = sync_r[1];
  wire s_part_reset = sync_r[0];

  // Range check used by every decoder
  function in_range;
    input [AW-1:0] addr;
    input [AW-1:0] base;
    input [AW-1:0] span;
    reg [AW:0] off;
    begin
      off = {1'b0, addr} - {1'b0, base};
      in_range = (addr >= base) && (off < {1'b0, span});
    end
  endfunction

  // ****************************************
  // Straps and sticky pin conversions
  // ****************************************
  reg strap_seen_r;
  reg [1:0] settle_r;
  reg cd_mode_r;
  reg synth_irq_mode_r;
  reg modem_mode_r;
  reg alt_cd_mode_r;

  // Straps caught once, third edge after release, once synchronisers hold pin levels
  always @(posedge i_clock) begin
    if (!i_rst_b) begin
      strap_seen_r <= 1'b0;
      settle_r <= 2'h0;
      cd_mode_r <= 1'b0;
      synth_irq_mode_r <= 1'b0;
    end else begin
      settle_r <= {settle_r[0], 1'b1};
      if (!strap_seen_r && settle_r[1]) begin
        strap_seen_r <= 1'b1;
        cd_mode_r <= !s_rd_strap;
        synth_irq_mode_r <= !s_wr_strap;
      end
    end
  end

  // Conversions hold until i_rst_b; part reset does not clear them
  always @(posedge i_clock) begin
    if (!i_rst_b) begin
      modem_mode_r <= 1'b0;
      alt_cd_mode_r <= 1'b0;
    end else begin
      if (cd_mode_r && i_modem_base != {AW{1'b0}})
        modem_mode_r <= 1'b1;
      if (!i_vol_ctrl_enable && i_alt_cd_base != {AW{1'b0}})
        alt_cd_mode_r <= 1'b1;
    end
  end

  // ****************************************
  // Address decode
  // ****************************************
  wire rd_act = !s_rd_b;
  wire wr_act = !s_wr_b;
  wire strobe = rd_act || wr_act;
  wire [AW-1:0] pspan = i_addr_bit2_enable ? `PPSM_SPAN_WIDE : `PPSM_SPAN_NARROW;
  wire [AW-1:0] alt_span = {{(AW-3){1'b0}}, i_alt_cd_span_m1} + {{(AW-1){1'b0}}, 1'b1};
  wire hit_synth = i_ext_synth_enable &&
                   (in_range(s_addr, i_synth_base, `PPSM_FM_SPAN) ||
                    in_range(s_addr, `PPSM_LEGACY_FM_BASE, `PPSM_FM_SPAN));
  wire hit_cd = cd_mode_r && in_range(s_addr, i_cd_base_a, pspan);
  wire hit_modem = modem_mode_r && in_range(s_addr, i_modem_base, pspan);
  wire hit_alt = alt_cd_mode_r && !i_vol_ctrl_enable && in_range(s_addr, i_alt_cd_base, alt_span);
  wire alt_plus1 = hit_alt && (s_addr == i_alt_cd_base + {{(AW-1){1'b0}}, 1'b1});
  wire hit_any = hit_synth || hit_cd || hit_modem || hit_alt;
  wire serial_on_pdata = i_serial_port_enable && i_serial_port_pin_select;
  wire no_drive = i_host_data_drive_disable || serial_on_pdata;

  // ****************************************
  // Registered outputs
  // ****************************************
  always @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_host_data <= {DW{1'b0}};
      o_host_data_oe <= 1'b0;
      o_periph_data <= {DW{1'b0}};
      o_periph_data_oe <= 1'b0;
      o_periph_addr <= 3'h0;
      o_periph_addr2_is_addr <= 1'b0;
      o_periph_read_strobe_b <= 1'b1;
      o_periph_write_strobe_b <= 1'b1;
      o_periph_reset <= 1'b1;
      o_synth_chip_select_b <= 1'b1;
      o_shared_pin <= 1'b0;
      o_shared_pin_oe <= 1'b0;
      o_cd_pins_are_upper_addr <= 1'b1;
      o_cd_chip_select_b <= 1'b1;
      o_cd_dma_ack_b <= 1'b1;
      o_modem_chip_select_b <= 1'b1;
      o_modem_pins_active <= 1'b0;
      o_alt_cd_active <= 1'b0;
      o_synth_irq <= 1'b0;
      o_cd_irq <= 1'b0;
      o_cd_dma_request <= 1'b0;
      o_modem_irq <= 1'b0;
    end else begin
      o_periph_reset <= s_part_reset;
      o_periph_read_strobe_b <= !(rd_act && hit_any);
      o_periph_write_strobe_b <= !(wr_act && hit_any);
      o_periph_data <= s_hdata;
      o_periph_data_oe <= wr_act && hit_any && !serial_on_pdata;
      o_periph_addr2_is_addr <= i_addr_bit2_enable;
      o_periph_addr <= {i_addr_bit2_enable ? s_addr[2] : i_general_ctrl_out0, s_addr[1:0]};
      o_synth_chip_select_b <= !(strobe && hit_synth);
      o_cd_chip_select_b <= !(strobe && hit_cd);
      o_modem_chip_select_b <= !(strobe && hit_modem);
      o_cd_dma_ack_b <= 1'b1;
      o_cd_pins_are_upper_addr <= !cd_mode_r;
      o_modem_pins_active <= modem_mode_r;
      o_alt_cd_active <= alt_cd_mode_r && !i_vol_ctrl_enable;
      o_host_data <= s_pdata;
      o_host_data_oe <= rd_act && hit_any && !no_drive &&
                        !(alt_plus1 && i_alt_cd_bit7_disable);
      if (i_vol_ctrl_enable) begin
        o_shared_pin <= s_vol_down;
        o_shared_pin_oe <= 1'b0;
      end else if (alt_cd_mode_r) begin
        o_shared_pin <= !(strobe && hit_alt);
        o_shared_pin_oe <= 1'b1;
      end else if (synth_irq_mode_r) begin
        o_shared_pin <= 1'b1;
        o_shared_pin_oe <= 1'b0;
      end else begin
        o_shared_pin <= i_general_ctrl_out1;
        o_shared_pin_oe <= 1'b1;
      end
      o_synth_irq <= synth_irq_mode_r && !i_vol_ctrl_enable && !alt_cd_mode_r &&
                     (s_synth_irq == i_synth_irq_polarity);
      o_cd_irq <= cd_mode_r && (s_cd_irq == i_cd_irq_polarity);
      o_cd_dma_request <= cd_mode_r && !modem_mode_r && s_cd_drq;
      o_modem_irq <= modem_mode_r && (s_modem_irq == i_modem_irq_polarity);
    end
  end

endmodule

// ---- test/ppsm_port_mux_assertions.sv ----
`timescale 1ns/1ps
module ppsm_port_mux_assertions (
  input wire i_clock,
  input wire i_rst_b,
  input wire i_host_rd_b,
  input wire i_host_wr_b,
  input wire i_vol_ctrl_enable,
  input wire i_host_data_drive_disable,
  input wire o_host_data_oe,
  input wire o_cd_chip_select_b,
  input wire o_synth_chip_select_b,
  input wire o_modem_chip_select_b,
  input wire o_modem_pins_active,
  input wire o_alt_cd_active,
  input wire o_shared_pin_oe
);
  // ****************
  // Timing checks
  // ****************
  reg [2:0] warm_r;
  wire [2:0] warm_nxt = (warm_r == 3'h7) ? warm_r : warm_r + 3'h1;
  wire live = i_rst_b && (warm_r > 3'h4);
  // Cycles since reset release
  always @(posedge i_clock) begin
    if (!i_rst_b) warm_r <= 3'h0;
    else warm_r <= warm_nxt;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!live);
  chk_cd_sel_strobe: assert property (!o_cd_chip_select_b |->
    !$past(i_host_rd_b, 3) || !$past(i_host_wr_b, 3)) else $error("cd select without strobe");
  chk_synth_sel_strobe: assert property (!o_synth_chip_select_b |->
    !$past(i_host_rd_b, 3) || !$past(i_host_wr_b, 3)) else $error("synth select idle");
  chk_modem_sel_gate: assert property (!o_modem_chip_select_b |->
    o_modem_pins_active) else $error("modem select before conversion");
  chk_modem_sticky: assert property (o_modem_pins_active |=>
    o_modem_pins_active) else $error("modem pins reverted");
  chk_alt_sticky: assert property ($fell(o_alt_cd_active) |->
    $past(i_vol_ctrl_enable)) else $error("alt select reverted");
  chk_vol_wins: assert property ($past(i_vol_ctrl_enable) |->
    !o_shared_pin_oe) else $error("shared pin driven in volume mode");
  chk_sdd_quiet: assert property ($past(i_host_data_drive_disable) |->
    !o_host_data_oe) else $error("host data driven while disabled");
  chk_oe_needs_rd: assert property (o_host_data_oe |->
    !$past(i_host_rd_b, 3)) else $error("host data driven without read");
endmodule

// ---- test/ppsm_periph_model.sv ----
`timescale 1ns/1ps
module ppsm_periph_model #(parameter [7:0] PAT = 8'hA5) (
  input wire i_clock,
  input wire i_sel_b,
  input wire i_rd_b,
  input wire [2:0] i_addr,
  output wire [7:0] o_data
);
  reg [7:0] last_r = 8'h00;
  // Selected read answers address pattern; released bus toggles
  assign o_data = (!i_sel_b && !i_rd_b) ? (PAT ^ {5'h00, i_addr}) : ~last_r;
  // Last value seen on the data bus
  always @(posedge i_clock) last_r <= o_data;
endmodule

// ---- test/peripheral_port_select_mux_tb.sv ----
`timescale 1ns/1ps
module peripheral_port_select_mux_tb;
  // ****************
  // Bench
  // ****************
  localparam [7:0] PAT = 8'hA5;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg rd_b = 1'b1;
  reg wr_b = 1'b1, wr_mode = 1'b0;
  reg [2:0] span = 3'h0;
  reg [9:0] a = 10'h000, sb = 10'h230, cb = 10'h170, ab = 10'h000, mb = 10'h000, off;
  reg [11:0] c = 12'h001;
  reg [3:0] irq = 4'h0;
  reg [31:0] seed = 32'h90B71A08;
  reg [7:0] last;
  reg hoe_q = 1'b0;
  reg [7:0] exq [$];
  integer miscompares = 0, n_checks = 0, cyc = 0, j;
  wire [7:0] pd, hd;
  wire [2:0] cs, iq, pa;
  wire hoe, prd, sp, spoe, up, mact, aact;
  // pullup on shared pin when undriven
  wire [3:0] cs4 = {sp | !spoe, cs};
  ppsm_port_mux dut (.i_clock(clk), .i_rst_b(rst_b), .i_host_addr(a), .i_host_rd_b(rd_b),
    .i_host_wr_b(wr_b), .i_host_data(8'h00), .i_synth_base(sb), .i_cd_base_a(cb),
    .i_alt_cd_base(ab), .i_modem_base(mb), .i_alt_cd_span_m1(span), .i_ext_synth_enable(c[0]),
    .i_addr_bit2_enable(c[1]), .i_vol_ctrl_enable(c[2]), .i_synth_irq_polarity(c[3]),
    .i_cd_irq_polarity(c[4]), .i_modem_irq_polarity(c[5]), .i_alt_cd_bit7_disable(c[6]),
    .i_host_data_drive_disable(c[7]), .i_serial_port_enable(c[8]),
    .i_serial_port_pin_select(c[9]), .i_general_ctrl_out0(c[10]), .i_general_ctrl_out1(c[11]),
    .i_vol_down(1'b0), .i_periph_read_strobe_strap(1'b0), .i_periph_write_strobe_strap(1'b0),
    .i_synth_irq_pin(irq[3]), .i_cd_irq_pin(irq[2]), .i_cd_dma_request_pin(irq[1]),
    .i_modem_irq_pin(irq[0]), .i_periph_data(pd), .i_part_reset(1'b0), .o_host_data(hd),
    .o_host_data_oe(hoe), .o_periph_data(), .o_periph_data_oe(), .o_periph_addr(pa),
    .o_periph_addr2_is_addr(), .o_periph_read_strobe_b(prd), .o_periph_write_strobe_b(),
    .o_periph_reset(), .o_synth_chip_select_b(cs[2]), .o_shared_pin(sp), .o_shared_pin_oe(spoe),
    .o_cd_pins_are_upper_addr(up), .o_cd_chip_select_b(cs[1]), .o_cd_dma_ack_b(),
    .o_modem_chip_select_b(cs[0]), .o_modem_pins_active(mact), .o_alt_cd_active(aact),
    .o_synth_irq(iq[2]), .o_cd_irq(iq[1]), .o_cd_dma_request(), .o_modem_irq(iq[0]));
  ppsm_periph_model #(.PAT(PAT)) far (.i_clock(clk), .i_sel_b(&cs4), .i_rd_b(prd),
    .i_addr(pa), .o_data(pd));
  // Clock generator
  initial forever #5 clk = ~clk;
  task chk(input [7:0] seen, input [7:0] exp, input [47:0] nm);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task rd(input [9:0] adr, input [3:0] ecs, input eoe, input [7:0] ed);
    begin
      @(posedge clk);
      a <= adr;
      if (wr_mode) wr_b <= 1'b0;
      else rd_b <= 1'b0;
      if (eoe) exq.push_back(ed);
      repeat (7) @(posedge clk);
      #1 chk(cs4, ecs, "csel");
      chk(hoe, eoe, "hoe");
      @(posedge clk);
      rd_b <= 1'b1;
      wr_b <= 1'b1;
      repeat (5) @(posedge clk);
    end
  endtask
  task cfg(input [11:0] v);
    begin
      @(posedge clk);
      c <= v;
      repeat (6) @(posedge clk);
      #1;
    end
  endtask
  // Read data compared as host drive ends
  always @(posedge clk) begin
    if (hoe) last <= hd;
    if (hoe_q && !hoe) chk(last, exq.pop_front(), "rdata");
    hoe_q <= hoe;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares = miscompares + 1;
      print_verdict;
    end
  end
  // Main sequence; synth, CD and modem bases aligned to eight, both straps low
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk(up, 1'b0, "upaddr");
    for (j = 0; j < 4; j = j + 1) begin
      off = $random(seed) & 10'h7;
      rd(cb + (off & 10'h3), 4'hD, 1'b1, PAT ^ off[1:0]);
      rd(10'h388 + off, 4'hB, 1'b1, PAT ^ off[1:0]);
    end
    rd(sb + 10'h2, 4'hB, 1'b1, PAT ^ 8'h02);
    cfg(12'h003);
    rd(cb + 10'h5, 4'hD, 1'b1, PAT ^ 8'h05);
    cfg(12'h081);
    rd(cb, 4'hD, 1'b0, 8'h00);
    cfg(12'h301);
    rd(cb, 4'hD, 1'b0, 8'h00);
    cfg(12'h001);
    wr_mode = 1'b1;
    rd(cb + 10'h1, 4'hD, 1'b0, 8'h00);
    wr_mode = 1'b0;
    mb <= 10'h2F8;
    rd(10'h2F8, 4'hE, 1'b1, PAT);
    mb <= 10'h000;
    cfg(12'h001);
    chk(mact, 1'b1, "mact");
    for (j = 0; j < 4; j = j + 1) begin
      irq <= {4{j[0]}};
      cfg({6'h00, {3{j[1]}}, 3'h1});
      chk(iq[2], j[0] == j[1], "sirq");
      chk(iq[1], j[0] == j[1], "cirq");
      chk(iq[0], j[0] == j[1], "mirq");
    end
    cfg(12'h005);
    chk(spoe, 1'b0, "voloe");
    ab <= 10'h376;
    cfg(12'h001);
    rd(ab, 4'h7, 1'b1, PAT ^ 8'h02);
    rd(ab + 10'h1, 4'hF, 1'b0, 8'h00);
    span <= 3'h1;
    cfg(12'h041);
    rd(ab + 10'h1, 4'h7, 1'b0, 8'h00);
    cfg(12'h001);
    rd(ab + 10'h1, 4'h7, 1'b1, PAT ^ 8'h03);
    ab <= 10'h000;
    cfg(12'h001);
    chk(aact, 1'b1, "aact");
    print_verdict;
  end
endmodule
bind ppsm_port_mux ppsm_port_mux_assertions chk_u (.i_clock(i_clock), .i_rst_b(i_rst_b),
  .i_host_rd_b(i_host_rd_b), .i_host_wr_b(i_host_wr_b), .i_vol_ctrl_enable(i_vol_ctrl_enable),
  .i_host_data_drive_disable(i_host_data_drive_disable), .o_host_data_oe(o_host_data_oe),
  .o_cd_chip_select_b(o_cd_chip_select_b), .o_synth_chip_select_b(o_synth_chip_select_b),
  .o_modem_chip_select_b(o_modem_chip_select_b), .o_modem_pins_active(o_modem_pins_active),
  .o_alt_cd_active(o_alt_cd_active), .o_shared_pin_oe(o_shared_pin_oe));
